//--- fspb_params.svh
`ifndef FSPB_PARAMS_SVH
`define FSPB_PARAMS_SVH

// software register offsets
`define FSPB_REG_CTRL 4'h0
`define FSPB_REG_ADDR 4'h1
`define FSPB_REG_WDATA 4'h2
`define FSPB_REG_RDATA 4'h3
`define FSPB_REG_STATUS 4'h4
// control fields
`define FSPB_CTRL_GO 0
`define FSPB_CTRL_OP_LSB 1
`define FSPB_CTRL_BYTE 4
`define FSPB_CTRL_TEMP 5
`define FSPB_CTRL_LOCKOK 6
// address bit positions on the flash
`define FSPB_ABIT_ZERO 0
`define FSPB_ABIT_ONE 1
`define FSPB_ABIT_SIX 6
`define FSPB_ABIT_NINE 9
// timing: phase time in ns and cycles at core_clk
`define FSPB_CLK_NS 100
`define FSPB_PHASE_NS 200
`define FSPB_PHASE_CYC (((`FSPB_PHASE_NS) + (`FSPB_CLK_NS) - 1) / (`FSPB_CLK_NS))
`define FSPB_RESET_VAL 16'h0000
`endif

//--- fspb_pkg.sv
package fspb_pkg;
	typedef enum logic [2:0] {
		FSPB_OP_READ = 3'h0,
		FSPB_OP_WRITE = 3'h1,
		FSPB_OP_IS_PROT = 3'h2,
		FSPB_OP_IS_UNPROT = 3'h3,
		FSPB_OP_HV_PROT = 3'h4,
		FSPB_OP_HV_UNPROT = 3'h5
	} fspb_op_e;

	typedef enum logic [1:0] {
		FSPB_ST_IDLE = 2'h0,
		FSPB_ST_SETUP = 2'h1,
		FSPB_ST_STROBE = 2'h2,
		FSPB_ST_HOLD = 2'h3
	} fspb_state_e;

	// flash control pins, active low names except the qualifiers
	typedef struct packed {
		logic chip_sel_n;
		logic out_en_n;
		logic wr_strobe_n;
		logic reset_pin_n;
		logic reset_pin_hv;
		logic out_en_hv;
		logic address_bit_nine_hv;
		logic byte_mode_n;
	} fspb_ctl_s;
endpackage

//--- fspb_phase_timer.sv
`timescale 1ns/1ps
`include "fspb_params.svh"
module fspb_phase_timer
	import fspb_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic start,
	output logic done
);
	logic [3:0] cnt_r;
	logic [3:0] cnt_nxt;
	logic done_nxt;
	logic done_r;

	// counts one bus phase, pulses done at the end
	always_comb begin
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		if (start) begin
			cnt_nxt = 4'(`FSPB_PHASE_CYC);
		end else if (cnt_r != 4'h0) begin
			cnt_nxt = cnt_r - 4'h1;
			done_nxt = (cnt_r == 4'h1);
		end
	end

	always_ff @(posedge core_clk) begin
		if (reset) begin
			cnt_r <= 4'h0;
			done_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	assign done = done_r;
endmodule

//--- fspb_data_pins.sv
`timescale 1ns/1ps
`include "fspb_params.svh"
module fspb_data_pins
	import fspb_pkg::*;
(
	input wire logic byte_mode,
	input wire logic drive,
	input wire logic [15:0] wdata,
	input wire logic lsb_addr,
	output logic [15:0] dq_oe,
	output logic [15:0] dq_out
);
	// byte mode: top data pin carries the lowest address bit
	always_comb begin
		dq_out = wdata;
		dq_oe = 16'h0000;
		if (byte_mode) begin
			dq_out = {lsb_addr, 7'h00, wdata[7:0]};
			dq_oe = drive ? 16'h80FF : 16'h8000;
		end else if (drive) begin
			dq_oe = 16'hFFFF;
		end
	end
endmodule

//--- fspb_host.sv
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "fspb_params.svh"
module fspb_host
	import fspb_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	output logic [31:0] sw_rdata,
	output fspb_ctl_s flash_ctl,
	output logic [18:0] flash_addr,
	output logic [15:0] flash_dq_out,
	output logic [15:0] flash_dq_oe,
	input wire logic [15:0] flash_dq_in
);
	// ************************************************
	// software registers
	// ************************************************
	fspb_op_e op_r, op_nxt;
	logic byte_r, byte_nxt;
	logic temp_r, temp_nxt;
	logic lockok_r, lockok_nxt;
	logic [18:0] addr_r, addr_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic [15:0] rdata_r, rdata_nxt;
	logic [31:0] sw_rdata_r, sw_rdata_nxt;
	logic go;
	logic busy;
	logic done_flag_r, done_flag_nxt;
	logic refused_r, refused_nxt;
	logic go_r, go_nxt;
	logic op_known;
	logic launch_ok;

	// ************************************************
	// bus cycle state
	// ************************************************
	fspb_state_e st_r, st_nxt;
	fspb_ctl_s ctl_r, ctl_nxt;
	logic [18:0] pin_addr_r, pin_addr_nxt;
	logic drive_r, drive_nxt;
	logic timer_start;
	logic timer_done;
	logic [15:0] dq_oe_c;
	logic [15:0] dq_out_c;
	logic [15:0] dq_oe_r;
	logic [15:0] dq_out_r;

	// software map: ctrl takes go (reads back 0) and holds op code, byte mode, temporary unprotect and the
	// supply-good enable; addr and wdata feed the next request; rdata holds the last
	// word read; status shows busy, done and refused, the last two sticky until read

	// a launch still in flight counts as busy, so nothing moves under it
	assign busy = (st_r != FSPB_ST_IDLE) || go_r;
	assign go = sw_wr && (sw_addr == `FSPB_REG_CTRL) && sw_wdata[`FSPB_CTRL_GO] && !busy;

	// only the six defined codes may reach the pins
	assign op_known = (op_r inside {FSPB_OP_READ, FSPB_OP_WRITE, FSPB_OP_IS_PROT, FSPB_OP_IS_UNPROT,
		FSPB_OP_HV_PROT, FSPB_OP_HV_UNPROT});
	// a bus cycle starts only for a known code with the supply reported good
	assign launch_ok = go_r && lockok_r && op_known;

	// register writes and read mux
	always_comb begin
		op_nxt = op_r;
		byte_nxt = byte_r;
		temp_nxt = temp_r;
		lockok_nxt = lockok_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		sw_rdata_nxt = 32'h00000000;
		done_flag_nxt = done_flag_r;
		refused_nxt = refused_r;
		if (sw_wr && !busy) begin
			if (sw_addr == `FSPB_REG_CTRL) begin
				op_nxt = fspb_op_e'(sw_wdata[`FSPB_CTRL_OP_LSB +: 3]);
				byte_nxt = sw_wdata[`FSPB_CTRL_BYTE];
				temp_nxt = sw_wdata[`FSPB_CTRL_TEMP];
				lockok_nxt = sw_wdata[`FSPB_CTRL_LOCKOK];
			end else if (sw_addr == `FSPB_REG_ADDR) begin
				addr_nxt = sw_wdata[18:0];
			end else if (sw_addr == `FSPB_REG_WDATA) begin
				wdata_nxt = sw_wdata[15:0];
			end
		end
		if (sw_rd) begin
			if (sw_addr == `FSPB_REG_CTRL) begin
				sw_rdata_nxt = {25'h0000000, lockok_r, temp_r, byte_r, op_r, 1'b0};
			end else if (sw_addr == `FSPB_REG_ADDR) begin
				sw_rdata_nxt = {13'h0000, addr_r};
			end else if (sw_addr == `FSPB_REG_WDATA) begin
				sw_rdata_nxt = {16'h0000, wdata_r};
			end else if (sw_addr == `FSPB_REG_RDATA) begin
				sw_rdata_nxt = {16'h0000, rdata_r};
			end else if (sw_addr == `FSPB_REG_STATUS) begin
				sw_rdata_nxt = {29'h00000000, refused_r, done_flag_r, busy};
			end
		end
		// set wins over clear on the done and refused flags
		if (sw_rd && sw_addr == `FSPB_REG_STATUS) begin
			done_flag_nxt = 1'b0;
			refused_nxt = 1'b0;
		end
		if (st_r == FSPB_ST_HOLD && timer_done) begin
			done_flag_nxt = 1'b1;
		end
		// a go that may not reach the pins is reported, not run
		if (go_r && !launch_ok) begin
			refused_nxt = 1'b1;
		end
	end

	// software registers, cleared by reset
	always_ff @(posedge core_clk) begin
		if (reset) begin
			op_r <= FSPB_OP_READ;
			byte_r <= 1'b0;
			temp_r <= 1'b0;
			lockok_r <= 1'b0;
			addr_r <= 19'h00000;
			wdata_r <= `FSPB_RESET_VAL;
			sw_rdata_r <= 32'h00000000;
			done_flag_r <= 1'b0;
			refused_r <= 1'b0;
		end else begin
			op_r <= op_nxt;
			byte_r <= byte_nxt;
			temp_r <= temp_nxt;
			lockok_r <= lockok_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			sw_rdata_r <= sw_rdata_nxt;
			done_flag_r <= done_flag_nxt;
			refused_r <= refused_nxt;
		end
	end

	// ************************************************
	// launch pipeline
	// ************************************************
	// the control word lands on the edge that takes go, so the sequencer
	// starts one cycle later and sees the new op, mode and enable bits
	always_comb begin
		go_nxt = go;
	end

	// holds the request for exactly one cycle
	always_ff @(posedge core_clk) begin
		if (reset) begin
			go_r <= 1'b0;
		end else begin
			go_r <= go_nxt;
		end
	end

	// ************************************************
	// flash bus sequencer
	// ************************************************
	// sequence: setup (address, qualifiers) -> strobe -> hold -> idle
	always_comb begin
		st_nxt = st_r;
		ctl_nxt = ctl_r;
		pin_addr_nxt = pin_addr_r;
		drive_nxt = drive_r;
		rdata_nxt = rdata_r;
		timer_start = 1'b0;
		if (st_r == FSPB_ST_IDLE) begin
			ctl_nxt.chip_sel_n = 1'b1;
			ctl_nxt.out_en_n = 1'b1;
			ctl_nxt.wr_strobe_n = 1'b1;
			ctl_nxt.out_en_hv = 1'b0;
			ctl_nxt.address_bit_nine_hv = 1'b0;
			ctl_nxt.byte_mode_n = !byte_r;
			// temporary unprotect held only while enabled
			ctl_nxt.reset_pin_hv = temp_r;
			ctl_nxt.reset_pin_n = 1'b1;
			drive_nxt = 1'b0;
		end
		case (st_r)
			FSPB_ST_IDLE: begin
				// start setup with select low and the address on the pins
				if (launch_ok) begin
					st_nxt = FSPB_ST_SETUP;
					timer_start = 1'b1;
					pin_addr_nxt = addr_r;
					ctl_nxt.chip_sel_n = 1'b0;
					// one sector per request; protect ordering is left to software
					case (op_r)
						FSPB_OP_IS_PROT, FSPB_OP_IS_UNPROT: begin
							// in-system via reset pin high voltage
							ctl_nxt.reset_pin_hv = 1'b1;
							pin_addr_nxt[`FSPB_ABIT_SIX] = (op_r == FSPB_OP_IS_UNPROT);
							pin_addr_nxt[`FSPB_ABIT_ONE] = 1'b1;
							pin_addr_nxt[`FSPB_ABIT_ZERO] = 1'b0;
						end
						FSPB_OP_HV_PROT, FSPB_OP_HV_UNPROT: begin
							// high voltage on bit nine and output enable
							ctl_nxt.out_en_hv = 1'b1;
							ctl_nxt.address_bit_nine_hv = 1'b1;
							pin_addr_nxt[`FSPB_ABIT_SIX] = (op_r == FSPB_OP_HV_UNPROT);
							pin_addr_nxt[`FSPB_ABIT_ONE] = 1'b1;
							pin_addr_nxt[`FSPB_ABIT_ZERO] = 1'b0;
						end
						default: begin
						end
					endcase
					// output enable low only on reads
					ctl_nxt.out_en_n = (op_r == FSPB_OP_READ) ? 1'b0 : 1'b1;
					drive_nxt = (op_r != FSPB_OP_READ);
				end
			end
			// address and qualifiers settle for a full phase
			FSPB_ST_SETUP: begin
				if (timer_done) begin
					st_nxt = FSPB_ST_STROBE;
					timer_start = 1'b1;
					// write strobe low with chip select low, output enable high
					ctl_nxt.wr_strobe_n = (op_r == FSPB_OP_READ);
				end
			end
			// strobe or output enable phase, read data taken at its end
			FSPB_ST_STROBE: begin
				if (timer_done) begin
					st_nxt = FSPB_ST_HOLD;
					timer_start = 1'b1;
					if (op_r == FSPB_OP_READ) begin
						rdata_nxt = byte_r ? {8'h00, flash_dq_in[7:0]} : flash_dq_in;
					end
					ctl_nxt.wr_strobe_n = 1'b1;
					ctl_nxt.out_en_n = 1'b1;
				end
			end
			// hold keeps address, data and select past the strobe rise
			FSPB_ST_HOLD: begin
				if (timer_done) begin
					st_nxt = FSPB_ST_IDLE;
					ctl_nxt.chip_sel_n = 1'b1;
					ctl_nxt.out_en_hv = 1'b0;
					ctl_nxt.address_bit_nine_hv = 1'b0;
					ctl_nxt.reset_pin_hv = temp_r;
					drive_nxt = 1'b0;
				end
			end
			default: begin
				st_nxt = FSPB_ST_IDLE;
			end
		endcase
	end

	// pin registers, every flash output launches from here
	always_ff @(posedge core_clk) begin
		if (reset) begin
			st_r <= FSPB_ST_IDLE;
			ctl_r <= '{chip_sel_n: 1'b1, out_en_n: 1'b1, wr_strobe_n: 1'b1, reset_pin_n: 1'b1,
				reset_pin_hv: 1'b0, out_en_hv: 1'b0, address_bit_nine_hv: 1'b0, byte_mode_n: 1'b1};
			pin_addr_r <= 19'h00000;
			drive_r <= 1'b0;
			rdata_r <= `FSPB_RESET_VAL;
			dq_oe_r <= 16'h0000;
			dq_out_r <= 16'h0000;
		end else begin
			st_r <= st_nxt;
			ctl_r <= ctl_nxt;
			pin_addr_r <= pin_addr_nxt;
			drive_r <= drive_nxt;
			rdata_r <= rdata_nxt;
			dq_oe_r <= dq_oe_c;
			dq_out_r <= dq_out_c;
		end
	end

	// ************************************************
	// helpers
	// ************************************************
	// one timer times all three phases, restarted at each step
	fspb_phase_timer u_timer (
		.core_clk(core_clk),
		.reset(reset),
		.start(timer_start),
		.done(timer_done)
	);

	fspb_data_pins u_pins (
		.byte_mode(byte_r),
		.drive(drive_nxt),
		.wdata(wdata_r),
		.lsb_addr(pin_addr_nxt[0]),
		.dq_oe(dq_oe_c),
		.dq_out(dq_out_c)
	);

	// ************************************************
	// outputs
	// ************************************************
	// straight from flip-flops, no logic after the registers
	assign sw_rdata = sw_rdata_r;
	assign flash_ctl = ctl_r;
	assign flash_addr = pin_addr_r;
	assign flash_dq_out = dq_out_r;
	assign flash_dq_oe = dq_oe_r;
endmodule

//--- fspb_flash_model.sv
`timescale 1ns/1ps
// ****
// flash device model
// ****
module fspb_flash_model
	import fspb_pkg::*;
(
	input wire fspb_ctl_s ctl,
	input wire logic [18:0] addr,
	input wire logic [15:0] dq_out,
	output logic [15:0] dq_in
);
	logic [15:0] mem [bit [17:0]];
	logic [7:0] prot = 8'h00;
	logic [15:0] rd_w;
	realtime t_fall = 0.0;
	wire logic [2:0] sec = addr[17:15];
	// strobe fall time for the glitch filter
	always @(negedge ctl.wr_strobe_n)
		t_fall = $realtime;
	// a strobe low since power-up (no fall seen) never commands
	always @(posedge ctl.wr_strobe_n) begin
		if (!ctl.chip_sel_n && (ctl.out_en_n || ctl.out_en_hv) && ctl.reset_pin_n &&
			t_fall > 0.0 && $realtime - t_fall >= 5.0) begin
			if ((ctl.reset_pin_hv || ctl.address_bit_nine_hv && ctl.out_en_hv) && addr[1:0] == 2'h2)
				prot = addr[6] ? 8'h00 : prot | (8'h01 << sec);
			else if (ctl.reset_pin_hv || !prot[sec])
				mem[addr[17:0]] = dq_out;
		end
	end
	// drive on a read only, else inverse of host value
	always @* begin
		rd_w = mem.exists(addr[17:0]) ? mem[addr[17:0]] : 16'hFFFF;
		dq_in = ~dq_out;
		if (!ctl.chip_sel_n && !ctl.out_en_n && ctl.wr_strobe_n && ctl.reset_pin_n)
			dq_in = ctl.byte_mode_n ? rd_w : {~dq_out[15:8], dq_out[15] ? rd_w[15:8] : rd_w[7:0]};
	end
endmodule

//--- fspb_host_monitor.sv
`timescale 1ns/1ps
module fspb_host_monitor
	import fspb_pkg::*;
(
	input wire logic core_clk,
	input wire logic reset,
	input wire logic [3:0] sw_addr,
	input wire logic [31:0] sw_wdata,
	input wire logic sw_wr,
	input wire logic sw_rd,
	input wire logic [31:0] sw_rdata,
	input wire fspb_ctl_s flash_ctl,
	input wire logic [18:0] flash_addr,
	input wire logic [15:0] flash_dq_out,
	input wire logic [15:0] flash_dq_oe,
	input wire logic [15:0] flash_dq_in
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (reset);
	// strobe steps
	sequence strobe_fall;
		$fell(flash_ctl.wr_strobe_n);
	endsequence
	sequence strobe_held;
		!flash_ctl.wr_strobe_n [*2];
	endsequence
	write_qual_a: assert property (!flash_ctl.wr_strobe_n |-> !flash_ctl.chip_sel_n && flash_ctl.out_en_n)
		else $error("strobe without select");
	strobe_width_a: assert property (strobe_fall |-> strobe_held)
		else $error("strobe too short");
	select_setup_a: assert property (strobe_fall |-> !$past(flash_ctl.chip_sel_n, 2))
		else $error("select late");
	no_contend_a: assert property (!flash_ctl.out_en_n |-> flash_dq_oe[14:0] == 15'h0000 &&
		flash_dq_oe[15] == !flash_ctl.byte_mode_n)
		else $error("data driven in read");
	byte_lanes_a: assert property (!flash_ctl.byte_mode_n && flash_dq_oe[15] |->
		flash_dq_oe[14:8] == 7'h00 && flash_dq_out[15] == flash_addr[0])
		else $error("byte lanes wrong");
	hv_pair_a: assert property (flash_ctl.address_bit_nine_hv |-> flash_ctl.out_en_hv && !flash_ctl.chip_sel_n)
		else $error("high voltage unpaired");
	hv_bits_a: assert property (flash_ctl.address_bit_nine_hv && !flash_ctl.wr_strobe_n |->
		flash_addr[1:0] == 2'h2)
		else $error("protect address bits");
	reset_pin_a: assert property (flash_ctl.reset_pin_n)
		else $error("reset pin low");
	reset_state_a: assert property ($fell(reset) |-> flash_ctl.wr_strobe_n && !flash_ctl.reset_pin_hv
		&& flash_dq_oe == 16'h0000)
		else $error("state after reset");
endmodule

//--- tb_fspb_host.sv
`timescale 1ns/1ps
module tb_fspb_host;
	import fspb_pkg::*;
	logic core_clk = 0, reset = 1, sw_wr = 0, sw_rd = 0, rd_d = 0;
	logic [3:0] sw_addr = 4'h0;
	logic [31:0] sw_wdata = 32'h0, sw_rdata;
	fspb_ctl_s flash_ctl;
	logic [18:0] flash_addr, a;
	logic [15:0] flash_dq_out, flash_dq_oe, flash_dq_in, d;
	logic [63:0] exp_q[$];
	logic [63:0] e;
	int n_fail = 0, total_checks = 0;
	integer seed = 42039;
	fspb_host dut_u (.*);
	fspb_flash_model flash_u (.ctl(flash_ctl), .addr(flash_addr), .dq_out(flash_dq_out), .dq_in(flash_dq_in));
	// clock
	initial forever #50 core_clk = ~core_clk;
	// ****
	// tasks
	// ****
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic wr(logic [3:0] ad, logic [31:0] v);
		@(posedge core_clk);
		sw_addr <= ad;
		sw_wdata <= v;
		sw_wr <= 1'b1;
		@(posedge core_clk);
		sw_wr <= 1'b0;
	endtask
	task automatic rd(logic [3:0] ad, logic [31:0] m, logic [31:0] v);
		exp_q.push_back({m, v});
		@(posedge core_clk);
		sw_addr <= ad;
		sw_rd <= 1'b1;
		@(posedge core_clk);
		sw_rd <= 1'b0;
	endtask
	task automatic op(logic [2:0] o, logic [18:0] ad, logic [15:0] v, logic [2:0] f);
		logic [2:0] st_exp;
		wr(4'h1, {13'h0, ad});
		wr(4'h2, {16'h0, v});
		wr(4'h0, {25'h0, f, o, 1'b1});
		repeat (2) @(posedge core_clk);
		repeat (40) begin
			rd(4'h4, 32'h0, 32'h0);
			#1;
			if (sw_rdata[0] === 1'b0)
				break;
		end
		// accepted: done only; lockout or unknown code: refused only
		st_exp = (f[2] && o < 3'h6) ? 3'h2 : 3'h4;
		total_checks++;
		if (sw_rdata[2:0] !== st_exp) begin
			n_fail++;
			$display("CHECK FAILED status expected %h seen %h", st_exp, sw_rdata[2:0]);
		end
	endtask
	task automatic xr(logic [18:0] ad, logic [15:0] v, logic [2:0] f, logic [31:0] m);
		op(3'h0, ad, 16'h0, f);
		rd(4'h3, m, {16'h0, v});
	endtask
	// compare each read answer with the oldest note
	always @(posedge core_clk) begin
		if (rd_d && exp_q.size() > 0) begin
			e = exp_q.pop_front();
			if (e[63:32] != 0) begin
				total_checks++;
				if ((sw_rdata & e[63:32]) !== (e[31:0] & e[63:32])) begin
					n_fail++;
					$display("CHECK FAILED sw_rdata expected %h seen %h", e[31:0], sw_rdata);
				end
			end
		end
		rd_d <= sw_rd;
	end
	// watchdog
	initial begin
		#500000;
		n_fail++;
		summarize();
	end
	// main sequence
	initial begin
		repeat (12) @(posedge core_clk);
		reset <= 1'b0;
		rd(4'h4, 32'hFFFFFFFF, 32'h0);
		for (int i = 0; i < 3; i++) begin
			a = 19'(($random(seed) & 19'h3FF00) | 19'h00020);
			d = 16'($random(seed));
			op(3'h1, a, d, 3'h4);
			xr(a, d, 3'h4, 32'hFFFF);
		end
		for (int k = 0; k < 2; k++) begin
			for (int s = 0; s < 8; s++)
				op(s[0] ? 3'h4 : 3'h2, {1'b0, s[2:0], 15'h0010}, 16'h0, 3'h4);
			if (k == 0) begin
				op(3'h1, 19'h18010, 16'h1234, 3'h4);
				xr(19'h18010, 16'hFFFF, 3'h4, 32'hFFFF);
				op(3'h1, 19'h18010, 16'h1234, 3'h6);
				xr(19'h18010, 16'h1234, 3'h4, 32'hFFFF);
				op(3'h1, 19'h18010, 16'h5678, 3'h4);
				xr(19'h18010, 16'h1234, 3'h4, 32'hFFFF);
			end
			op(k ? 3'h5 : 3'h3, 19'h00010, 16'h0, 3'h4);
			d = k ? 16'h0F10 : 16'h0F0F;
			op(3'h1, 19'h30010, d, 3'h4);
			xr(19'h30010, d, 3'h4, 32'hFFFF);
		end
		op(3'h1, 19'h38010, 16'hAAAA, 3'h0);
		xr(19'h38010, 16'hFFFF, 3'h4, 32'hFFFF);
		op(3'h7, 19'h30010, 16'h0, 3'h4);
		op(3'h2, 19'h30010, 16'h0, 3'h4);
		op(3'h1, 19'h30010, 16'h5555, 3'h4);
		xr(19'h30010, d, 3'h4, 32'hFFFF);
		xr(19'h30010, d, 3'h5, 32'h00FF);
		repeat (3) @(posedge core_clk);
		summarize();
	end
endmodule
bind fspb_host fspb_host_monitor mon_u (.*);
